/* File: logic/pending_clear_bits_pkg.sv */
/*
 * package for the clear-pending word covering interrupts 32 to 63:
 * register offsets, implemented-bit mask, bus carrier types.
 * assumes a 32-bit apb slave port and one system clock.
 */
`default_nettype none
package pend_clear_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CLEAR_WORD_OFFSET  = 12'h000;
	localparam logic [11:0] IRQ_STATUS_OFFSET  = 12'h004;
	localparam logic [11:0] IRQ_MASK_OFFSET    = 12'h008;
	// bits 27:26, 23:5 and 3:0 map to interrupts 59:58, 55:37, 35:32
	localparam logic [31:0] IMPL_MASK          = 32'h0CFF_FFEF;
	localparam logic [31:0] CLEAR_WORD_RESET   = 32'h0000_0000;
	localparam logic [1:0]  IRQ_STATUS_RESET   = 2'h0;
	localparam logic [1:0]  IRQ_MASK_RESET     = 2'h0;
	// status bit positions
	localparam int          EV_CLEAR_DONE      = 0;
	localparam int          EV_CLEAR_BLOCKED   = 1;

	// ----------------------------------------------------------------
	// bus carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;
endpackage
`default_nettype wire

/* File: logic/irq_clear_pending_bank2.sv */
/*
 * clear-pending word for interrupts 32 to 63, with an apb slave port,
 * a small sticky event status, a mask and one interrupt level.
 * the word itself holds no state: a read shows the pending levels as
 * they stand, and a write sends a one-cycle clear pulse outward.
 * assumes pending and active levels come from logic on the same clock,
 * so neither passes a synchroniser; an apb master that holds its
 * request until pready; pending logic that acts on a one-cycle pulse.
 */
// The register offsets and the APB slave port were chosen for this implementation.
// What this block does
// - writing one clears that interrupt's pending
// - interrupts in service ignore the clear
// - writing zero changes nothing
// - read returns current pending status
// - bit positions map to interrupts 59..32
`timescale 1ns/1ps
`default_nettype none
module irq_clear_pending_bank2
	import pend_clear_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire pend_clear_pkg::apb_req_t apb_req,
	output var  pend_clear_pkg::apb_rsp_t apb_rsp,
	input  wire logic [31:0]         pending_in,
	input  wire logic [31:0]         active_in,
	output logic [31:0]              pending_clear_bits,
	output logic                     irq
);
	import pend_clear_pkg::*;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic [31:0] word_of(input logic [31:0] v);
		word_of = v & IMPL_MASK;
	endfunction

	wire logic        setup_ph   = apb_req.psel && !apb_req.penable;
	wire logic        wr_take    = apb_req.psel && apb_req.penable && apb_req.pwrite
	                               && apb_rsp.pready;
	wire logic        rd_setup   = setup_ph && !apb_req.pwrite;
	wire logic        hit_clear  = apb_req.paddr == CLEAR_WORD_OFFSET;
	wire logic        hit_status = apb_req.paddr == IRQ_STATUS_OFFSET;
	wire logic        hit_mask   = apb_req.paddr == IRQ_MASK_OFFSET;
	wire logic        hit_any    = hit_clear || hit_status || hit_mask;
	// only ones on implemented bits clear; zeros and reserved bits do nothing
	wire logic [31:0] want_clr   = (wr_take && hit_clear) ? word_of(apb_req.pwdata)
	                               : 32'h0000_0000;
	wire logic [31:0] do_clr     = want_clr & ~active_in;
	wire logic [31:0] blk_clr    = want_clr & active_in;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [1:0]  status_r;
	logic [1:0]  status_nxt;
	logic [1:0]  mask_r;
	logic [31:0] rdata_nxt;
	logic        slverr_nxt;
	wire logic [1:0] ev;
	// event bits by position, so the status layout lives in the package
	assign ev[EV_CLEAR_DONE]    = |do_clr;
	assign ev[EV_CLEAR_BLOCKED] = |blk_clr;
	// write-one-to-clear strobe and next mask, shared by register and irq
	wire logic [1:0] w1c      = (wr_take && hit_status) ? apb_req.pwdata[1:0] : 2'h0;
	wire logic [1:0] mask_nxt = (wr_take && hit_mask) ? apb_req.pwdata[1:0] : mask_r;

	// set wins over a simultaneous write-one-to-clear
	assign status_nxt = (status_r & ~w1c) | ev;

	// read data captured in the setup cycle, shown in the access cycle
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (hit_clear)
			rdata_nxt = word_of(pending_in);
		else if (hit_status)
			rdata_nxt = {30'h0, status_r};
		else if (hit_mask)
			rdata_nxt = {30'h0, mask_r};
		slverr_nxt = !hit_any;
	end

	// bus answer: one wait-free access phase
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			apb_rsp <= '0;
		else
		begin
			apb_rsp.pready  <= setup_ph;
			apb_rsp.pslverr <= setup_ph && slverr_nxt;
			apb_rsp.prdata  <= rd_setup ? rdata_nxt : 32'h0000_0000;
		end
	end

	// clear pulse toward the pending logic, one cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pending_clear_bits <= CLEAR_WORD_RESET;
		else
			pending_clear_bits <= do_clr;
	end

	// event status, mask and interrupt level
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_r <= IRQ_STATUS_RESET;
			mask_r   <= IRQ_MASK_RESET;
			irq      <= 1'b0;
		end
		else
		begin
			status_r <= status_nxt;
			mask_r   <= mask_nxt;
			irq      <= |(status_nxt & mask_nxt);
		end
	end

	// ----------------------------------------------------------------
	// checks: bus answer
	// ----------------------------------------------------------------
	// a setup cycle with psel high and penable low
	sequence seq_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	// the answer stands exactly one cycle
	sequence seq_answer;
		apb_rsp.pready ##1 !apb_rsp.pready;
	endsequence
	// a write to the clear word taken at this edge
	sequence seq_clear_write;
		wr_take && hit_clear;
	endsequence
	// a read of the clear word in its setup cycle
	sequence seq_read_clear;
		rd_setup && hit_clear;
	endsequence

	// no wait states: ready one cycle after setup, then low again
	chk_ready_timing: assert property (@(posedge clk) disable iff (!rst_n)
		seq_setup |=> seq_answer)
		else $error("ready not one cycle after setup");

	// ready never rises without a setup cycle before it
	chk_ready_after_setup: assert property (@(posedge clk) disable iff (!rst_n)
		apb_rsp.pready |-> $past(setup_ph))
		else $error("ready without setup");

	// unmapped offsets answer with an error
	chk_slverr_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
		(setup_ph && !hit_any) |=> apb_rsp.pslverr)
		else $error("unmapped access without error");

	// mapped offsets answer cleanly
	chk_slverr_mapped: assert property (@(posedge clk) disable iff (!rst_n)
		(setup_ph && hit_any) |=> !apb_rsp.pslverr)
		else $error("mapped access with error");

	// outside the access cycle the answer lines rest at zero
	chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		!apb_rsp.pready |-> (!apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000))
		else $error("answer lines busy while idle");

	// writes return no read data
	chk_write_no_data: assert property (@(posedge clk) disable iff (!rst_n)
		(setup_ph && apb_req.pwrite) |=> apb_rsp.prdata == 32'h0000_0000)
		else $error("read data on a write");

	// unmapped reads return zero
	chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(setup_ph && !hit_any) |=> apb_rsp.prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// ----------------------------------------------------------------
	// checks: clear pulse
	// ----------------------------------------------------------------
	// lowest bit of the word clears interrupt 32
	chk_clear_reaches_out: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_take && hit_clear && apb_req.pwdata[0] && !active_in[0])
		|=> pending_clear_bits[0])
		else $error("clear write did not pulse clear bit");

	// top implemented bit clears interrupt 59
	chk_clear_high_bit: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_take && hit_clear && apb_req.pwdata[27] && !active_in[27])
		|=> pending_clear_bits[27])
		else $error("clear of top bit lost");

	// lowest bit of the middle range clears interrupt 37
	chk_clear_mid_bit: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_take && hit_clear && apb_req.pwdata[5] && !active_in[5])
		|=> pending_clear_bits[5])
		else $error("clear of middle bit lost");

	// one interrupt in service keeps its state
	chk_active_kept: assert property (@(posedge clk) disable iff (!rst_n)
		(active_in[3] && wr_take) |=> !pending_clear_bits[3])
		else $error("clear reached interrupt in service");

	// no interrupt in service at the write edge is cleared
	chk_active_any: assert property (@(posedge clk) disable iff (!rst_n)
		seq_clear_write |=> (pending_clear_bits & $past(active_in)) == 32'h0000_0000)
		else $error("clear reached an active interrupt");

	// no pulse at all without a clear write
	chk_zero_nothing: assert property (@(posedge clk) disable iff (!rst_n)
		!(wr_take && hit_clear) |=> pending_clear_bits == 32'h0000_0000)
		else $error("clear pulse without clear write");

	// a zero bit in the written word clears nothing
	chk_zero_bit_kept: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_take && hit_clear && !apb_req.pwdata[5]) |=> !pending_clear_bits[5])
		else $error("zero bit produced a clear");

	// the pulse lasts one cycle; back-to-back writes leave a gap
	chk_clear_one_shot: assert property (@(posedge clk) disable iff (!rst_n)
		pending_clear_bits != 32'h0000_0000 |=> pending_clear_bits == 32'h0000_0000)
		else $error("clear pulse longer than one cycle");

	// a pulse is always the echo of a taken clear write
	chk_pulse_needs_take: assert property (@(posedge clk) disable iff (!rst_n)
		pending_clear_bits != 32'h0000_0000 |-> ($past(wr_take) && $past(hit_clear)))
		else $error("clear pulse without taken write");

	// the pulse never touches an unmapped position
	chk_map_bits: assert property (@(posedge clk) disable iff (!rst_n)
		(pending_clear_bits & ~IMPL_MASK) == 32'h0000_0000)
		else $error("clear on unmapped bit");

	// reserved positions ignore whatever was written there
	chk_reserved_clear: assert property (@(posedge clk) disable iff (!rst_n)
		seq_clear_write |=> (pending_clear_bits[31:28] == 4'h0
		&& pending_clear_bits[25:24] == 2'h0 && !pending_clear_bits[4]))
		else $error("reserved bit produced a clear");

	// ----------------------------------------------------------------
	// checks: read data
	// ----------------------------------------------------------------
	// the clear word reads the pending levels of the setup cycle
	chk_read_pending: assert property (@(posedge clk) disable iff (!rst_n)
		seq_read_clear |=> apb_rsp.prdata == word_of($past(pending_in)))
		else $error("read did not return pending state");

	// the status word reads back the sticky bits
	chk_read_status: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_setup && hit_status) |=> apb_rsp.prdata == {30'h0, $past(status_r)})
		else $error("status read wrong");

	// the mask word reads back the mask
	chk_read_mask: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_setup && hit_mask) |=> apb_rsp.prdata == {30'h0, $past(mask_r)})
		else $error("mask read wrong");

	// reserved positions read as zero
	chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(apb_rsp.prdata & ~IMPL_MASK) == 32'h0000_0000)
		else $error("reserved bits read non-zero");

	// ----------------------------------------------------------------
	// checks: events and interrupt
	// ----------------------------------------------------------------
	// an applied clear sets its sticky bit
	chk_done_event: assert property (@(posedge clk) disable iff (!rst_n)
		(|do_clr) |=> status_r[EV_CLEAR_DONE])
		else $error("applied clear not flagged");

	// a blocked clear sets its sticky bit
	chk_blocked_event: assert property (@(posedge clk) disable iff (!rst_n)
		(|blk_clr) |=> status_r[EV_CLEAR_BLOCKED])
		else $error("blocked clear not flagged");

	// a set bit stays until a one is written to it
	chk_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		(status_r[EV_CLEAR_DONE] && !w1c[EV_CLEAR_DONE]) |=> status_r[EV_CLEAR_DONE])
		else $error("status bit lost without clear");

	// writing a one clears the done bit when no event meets it
	chk_status_clears: assert property (@(posedge clk) disable iff (!rst_n)
		(w1c[EV_CLEAR_DONE] && !ev[EV_CLEAR_DONE]) |=> !status_r[EV_CLEAR_DONE])
		else $error("done bit did not clear");

	// writing a one clears the blocked bit when no event meets it
	chk_blocked_clears: assert property (@(posedge clk) disable iff (!rst_n)
		(w1c[EV_CLEAR_BLOCKED] && !ev[EV_CLEAR_BLOCKED]) |=> !status_r[EV_CLEAR_BLOCKED])
		else $error("blocked bit did not clear");

	// an event in the cycle of its clear wins
	chk_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		(w1c[EV_CLEAR_DONE] && ev[EV_CLEAR_DONE]) |=> status_r[EV_CLEAR_DONE])
		else $error("clear beat a simultaneous event");

	// a mask write lands at its edge
	chk_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_take && hit_mask) |=> mask_r == $past(mask_nxt))
		else $error("mask write lost");

	// nothing else moves the mask
	chk_mask_holds: assert property (@(posedge clk) disable iff (!rst_n)
		!(wr_take && hit_mask) |=> $stable(mask_r))
		else $error("mask changed without write");

	// no interrupt without an unmasked status bit
	chk_irq_follow: assert property (@(posedge clk) disable iff (!rst_n)
		irq |-> |(status_r & mask_r))
		else $error("irq without masked status");

	// an unmasked status bit always raises the interrupt
	chk_irq_rise: assert property (@(posedge clk) disable iff (!rst_n)
		|(status_r & mask_r) |-> irq)
		else $error("irq low with masked status");
endmodule // irq_clear_pending_bank2
`default_nettype wire

/* File: bench/tb_irq_clear_pending_bank2.sv */
/* bench for the clear-pending word: random clears, reads, events, irq.
   assumes the design package and one 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_irq_clear_pending_bank2;
	import pend_clear_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        irq;
	logic        err;
	apb_req_t    req;
	apb_rsp_t    rsp;
	logic [31:0] pend, act, clr, rd, wd;
	int          bad_count, samples_checked, cyc;
	irq_clear_pending_bank2 i_dut (.clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
		.pending_in(pend), .active_in(act), .pending_clear_bits(clr), .irq(irq));
	// ----
	// helpers
	// ----
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// one apb cycle; an edge passes first so a release never meets a new setup
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----
	// clock, watchdog, tests
	// ----
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ceiling well above the few hundred cycles the tests need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			results();
		end
	end
	initial
	begin
		rst_n = 1'b0;
		req = '0;
		pend = '0;
		act = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		void'($urandom(32'hA8D93B87));
		apb(1'b1, IRQ_MASK_OFFSET, 32'h0000_0003);
		for (int i = 0; i < 40; i++)
		begin
			pend <= $urandom;
			act <= (i < 3) ? 32'h0 : $urandom;
			wd = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : (i == 2) ? ~IMPL_MASK : $urandom;
			apb(1'b0, CLEAR_WORD_OFFSET, 32'h0);
			chk("read", rd, pend & IMPL_MASK);
			chk("read err", {31'h0, err}, 32'h0);
			pend <= 32'hFFFF_FFFF;
			apb(1'b1, CLEAR_WORD_OFFSET, wd);
			#1 chk("clear", clr, wd & IMPL_MASK & ~act);
		end
		$display("test random done");
		act <= '0;
		apb(1'b1, IRQ_STATUS_OFFSET, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk("irq clr", {31'h0, irq}, 32'h0);
		apb(1'b1, CLEAR_WORD_OFFSET, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk("irq set", {31'h0, irq}, 32'h1);
		apb(1'b1, IRQ_STATUS_OFFSET, 32'h0000_0003);
		apb(1'b1, IRQ_MASK_OFFSET, 32'h0);
		act <= 32'h0000_0001;
		apb(1'b1, CLEAR_WORD_OFFSET, 32'h0000_0001);
		#1 chk("blocked", clr, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq mask", {31'h0, irq}, 32'h0);
		apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
		chk("status", rd, 32'h2);
		$display("test irq done");
		apb(1'b0, 12'h00C, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		chk("unmapped read", rd, 32'h0);
		$display("test unmapped done");
		results();
	end
endmodule // tb_irq_clear_pending_bank2
`default_nettype wire
